// *** include/lrs_pkg.sv ***
/*
  Shared constants and types of the two-wire register slave: the internal
  register map, reset values, bit counts and the state and phase encodings.
  Assumes it is compiled before every other file of the block.
*/
`default_nettype none

package lrs_pkg;

  // Internal register map, one byte per address
  localparam logic [7:0] LRS_ADDR_STATUS1 = 8'h00; // First status register
  localparam logic [7:0] LRS_ADDR_STATUS2 = 8'h01; // Second status register
  localparam logic [7:0] LRS_ADDR_DATA1 = 8'h02; // First data register
  localparam logic [7:0] LRS_ADDR_DATA4 = 8'h05; // Last data register
  localparam int LRS_NUM_DATA = 4; // Count of data registers

  // Reset value of every data register bit
  localparam logic [7:0] LRS_DATA_RESET = 8'h00;
  // Value returned for an address outside the map
  localparam logic [7:0] LRS_UNMAPPED_READ = 8'h00;

  // Bits per byte on the wire, and the bit count that ends a byte
  localparam logic [3:0] LRS_BYTE_BITS = 4'h8;
  localparam logic [3:0] LRS_LAST_TX_BIT = 4'h7;

  // Position of the read/write flag in the chip address byte
  localparam int LRS_RW_BIT = 0;

  // Transfer states, Gray coded along idle, receive, ack, send, master ack
  typedef enum logic [2:0] {
    LRS_ST_IDLE = 3'h0,
    LRS_ST_RX = 3'h1,
    LRS_ST_ACK = 3'h3,
    LRS_ST_TX = 3'h2,
    LRS_ST_MACK = 3'h6
  } lrs_state_t;

  // Which byte of the transfer is being received
  typedef enum logic [1:0] {
    LRS_PH_CHIP = 2'h0,
    LRS_PH_REG = 2'h1,
    LRS_PH_DATA = 2'h3
  } lrs_phase_t;

endpackage

`default_nettype wire

// *** include/lrs_regs_if.sv ***
/*
  Register access bundle between the serial engine and the register store:
  one shared byte address, a write strobe with its data, and the read data.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface lrs_regs_if;
  logic wrEn; // One-cycle write strobe
  logic [7:0] addr; // Register pointer, for reads and writes
  logic [7:0] wrData; // Byte to store
  logic [7:0] rdData; // Registered contents of addr

  // Serial engine side
  modport engine (
    output wrEn,
    output addr,
    output wrData,
    input rdData
  );

  // Register store side
  modport store (
    input wrEn,
    input addr,
    input wrData,
    output rdData
  );
endinterface

`default_nettype wire

// *** design/lrs_reg_mem.sv ***
/*
  Register store: two read-only status bytes fed by the device and four
  read/write data bytes, with read data out of a register.
  Assumes status inputs come from logic on the same clock.
*/
`default_nettype none

module lrs_reg_mem
  import lrs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  lrs_regs_if.store regs,
  input wire logic [7:0] status1,
  input wire logic [7:0] status2,
  output logic [31:0] ctrlData
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  // Data register array, cleared at power-on
  logic [7:0] dataReg [LRS_NUM_DATA];
  // Address falls on a data register
  wire isData = (regs.addr >= LRS_ADDR_DATA1) &&
    (regs.addr <= LRS_ADDR_DATA4);
  // Index into the data array
  wire [1:0] dataIdx = 2'(regs.addr - LRS_ADDR_DATA1);
  // Selected read byte
  wire [7:0] rdNext = (regs.addr == LRS_ADDR_STATUS1) ? status1 :
    (regs.addr == LRS_ADDR_STATUS2) ? status2 :
    isData ? dataReg[dataIdx] : LRS_UNMAPPED_READ;

  ////////////////////////////////////////////////////////////////////////
  // Storage

  // Writes outside the data range are dropped; status is not writable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < LRS_NUM_DATA; i++)
        dataReg[i] <= LRS_DATA_RESET;
    end
    else if (regs.wrEn && isData)
    begin
      dataReg[dataIdx] <= regs.wrData;
    end
  end

  // Read data registered so the engine sees a stable byte
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      regs.rdData <= LRS_UNMAPPED_READ;
    else
      regs.rdData <= rdNext;
  end

  // Data bytes out to the device, first register in the low byte
  always_comb
  begin
    for (int i = 0; i < LRS_NUM_DATA; i++)
      ctrlData[8*i +: 8] = dataReg[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // A byte stored to the first data register shows on ctrlData next cycle, and on rdData a cycle later if still addressed
  AST_DATA_READBACK: assert property (
    @(posedge clk) disable iff (sys_rst)
    (regs.wrEn && regs.addr == LRS_ADDR_DATA1) |=>
      ctrlData[7:0] == $past(regs.wrData) ##1
      (regs.addr != LRS_ADDR_DATA1 || regs.rdData == ctrlData[7:0]))
    else $error("data register lost a written byte");

endmodule

`default_nettype wire

// *** design/lrs_i2c_slave.sv ***
/*
  Two-wire serial register slave. Receives chip address, register address
  and data bytes from a bus master, acknowledges them, stores data with an
  auto-incrementing pointer and sends register bytes back on reads.
  Assumes the serial clock is far slower than clk (each half period at
  least four clk cycles) and that the open-drain pins are resolved outside.
*/
`default_nettype none

module lrs_i2c_slave
  import lrs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic uvloActive,
  input wire logic [6:0] chipAddr,
  input wire logic [7:0] status1,
  input wire logic [7:0] status2,
  output logic [31:0] ctrlData
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // First stages, read only by the second stages
  logic sclMeta_reg, sdaMeta_reg, uvloMeta_reg;
  logic [6:0] chipMeta_reg;
  // Second stages, safe to decode
  logic sclS_reg, sdaS_reg, uvloS_reg;
  logic [6:0] chipS_reg;
  // Previous synchronised levels for edge finding
  logic sclD_reg, sdaD_reg;

  // Two flops on every pin from outside the clock domain
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {sclMeta_reg, sclS_reg, sclD_reg} <= 3'h7; // Idle bus is high
      {sdaMeta_reg, sdaS_reg, sdaD_reg} <= 3'h7;
      {uvloMeta_reg, uvloS_reg} <= 2'h3; // Assume lockout until seen
      chipMeta_reg <= 7'h00;
      chipS_reg <= 7'h00;
    end
    else
    begin
      {sclMeta_reg, sclS_reg, sclD_reg} <= {sclIn, sclMeta_reg, sclS_reg};
      {sdaMeta_reg, sdaS_reg, sdaD_reg} <= {sdaIn, sdaMeta_reg, sdaS_reg};
      {uvloMeta_reg, uvloS_reg} <= {uvloActive, uvloMeta_reg};
      chipMeta_reg <= chipAddr;
      chipS_reg <= chipMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus event decode

  // Clock edges
  wire sclRise = sclS_reg && !sclD_reg;
  wire sclFall = !sclS_reg && sclD_reg;
  // Data moving while clock stays high marks a frame boundary
  wire startSeen = sclS_reg && sclD_reg && !sdaS_reg && sdaD_reg;
  wire stopSeen = sclS_reg && sclD_reg && sdaS_reg && !sdaD_reg;

  ////////////////////////////////////////////////////////////////////////
  // Engine state

  lrs_state_t state_reg, state_next; // Transfer state
  lrs_phase_t phase_reg, phase_next; // Byte being received
  logic [3:0] bitCnt_reg, bitCnt_next; // Bits of current byte
  logic [7:0] rxShift_reg, rxShift_next; // Incoming byte
  logic [7:0] txShift_reg, txShift_next; // Outgoing byte
  logic [7:0] ptr_reg, ptr_next; // Register pointer
  logic rw_reg, rw_next; // Read transfer when set
  logic ackLow_reg, ackLow_next; // Master acked last sent byte
  logic oeN_reg, oeN_next; // Low while pulling data low
  logic wrEn_reg, wrEn_next; // Store strobe

  lrs_regs_if regs ();

  // Full byte received, judged on the falling edge after bit eight
  wire byteDone = sclFall && (state_reg == LRS_ST_RX) &&
    (bitCnt_reg == LRS_BYTE_BITS);
  // Chip address byte names this device
  wire addrMatch = (rxShift_reg[7:1] == chipS_reg);
  // Acknowledge only when supply is good
  wire ackOeN = uvloS_reg;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Output changes are made on clock falls, apart from the release on start or stop, so data is steady high
  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    bitCnt_next = bitCnt_reg;
    rxShift_next = rxShift_reg;
    txShift_next = txShift_reg;
    ptr_next = wrEn_reg ? ptr_reg + 8'h01 : ptr_reg;
    rw_next = rw_reg;
    ackLow_next = ackLow_reg;
    oeN_next = oeN_reg;
    wrEn_next = 1'b0;
    if (stopSeen)
    begin
      // Stop ends any transfer and frees the line
      state_next = LRS_ST_IDLE;
      oeN_next = 1'b1;
    end
    else if (startSeen)
    begin
      // Each start begins with a chip address byte
      state_next = LRS_ST_RX;
      phase_next = LRS_PH_CHIP;
      bitCnt_next = 4'h0;
      oeN_next = 1'b1;
    end
    else
    begin
      case (state_reg)
        LRS_ST_RX:
        begin
          if (sclRise && bitCnt_reg != LRS_BYTE_BITS)
          begin
            // Shift in on rising clock, most significant bit first
            rxShift_next = {rxShift_reg[6:0], sdaS_reg};
            bitCnt_next = bitCnt_reg + 4'h1;
          end
          else if (byteDone)
          begin
            state_next = LRS_ST_ACK;
            oeN_next = ackOeN;
            case (phase_reg)
              LRS_PH_CHIP:
              begin
                rw_next = rxShift_reg[LRS_RW_BIT];
                phase_next = rxShift_reg[LRS_RW_BIT] ? LRS_PH_DATA
                  : LRS_PH_REG;
                if (!addrMatch)
                begin
                  // Not ours: stay silent until the next start
                  state_next = LRS_ST_IDLE;
                  oeN_next = 1'b1;
                end
              end
              LRS_PH_REG:
              begin
                ptr_next = rxShift_reg;
                phase_next = LRS_PH_DATA;
              end
              default:
                wrEn_next = 1'b1;
            endcase
          end
        end
        LRS_ST_ACK:
        begin
          if (sclFall && rw_reg)
          begin
            // Read: first data bit goes out as the ack ends
            state_next = LRS_ST_TX;
            txShift_next = regs.rdData;
            oeN_next = regs.rdData[7];
            bitCnt_next = 4'h0;
          end
          else if (sclFall)
          begin
            state_next = LRS_ST_RX;
            oeN_next = 1'b1;
            bitCnt_next = 4'h0;
          end
        end
        LRS_ST_TX:
        begin
          if (sclFall && bitCnt_reg == LRS_LAST_TX_BIT)
          begin
            // Byte sent: hand the line to the master for its ack
            state_next = LRS_ST_MACK;
            oeN_next = 1'b1;
          end
          else if (sclFall)
          begin
            txShift_next = {txShift_reg[6:0], 1'b0};
            oeN_next = txShift_reg[6];
            bitCnt_next = bitCnt_reg + 4'h1;
          end
        end
        LRS_ST_MACK:
        begin
          if (sclRise)
          begin
            // Advance early so the next byte is read by the fall
            ackLow_next = !sdaS_reg;
            ptr_next = sdaS_reg ? ptr_reg : ptr_reg + 8'h01;
          end
          else if (sclFall && ackLow_reg)
          begin
            state_next = LRS_ST_TX;
            txShift_next = regs.rdData;
            oeN_next = regs.rdData[7];
            bitCnt_next = 4'h0;
          end
          else if (sclFall)
          begin
            state_next = LRS_ST_IDLE;
            oeN_next = 1'b1;
          end
        end
        default:
          oeN_next = 1'b1; // Idle never drives
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers

  // Pointer resets to the first status register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= LRS_ST_IDLE;
      phase_reg <= LRS_PH_CHIP;
      bitCnt_reg <= 4'h0;
      rxShift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      ptr_reg <= LRS_ADDR_STATUS1;
      rw_reg <= 1'b0;
      ackLow_reg <= 1'b0;
      oeN_reg <= 1'b1;
      wrEn_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      bitCnt_reg <= bitCnt_next;
      rxShift_reg <= rxShift_next;
      txShift_reg <= txShift_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      ackLow_reg <= ackLow_next;
      oeN_reg <= oeN_next;
      wrEn_reg <= wrEn_next;
    end
  end

  // Open-drain: the driven level is always low, only the enable moves
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sdaOut <= 1'b0;
    else
      sdaOut <= 1'b0;
  end

  assign sdaOe_n = oeN_reg;
  assign regs.wrEn = wrEn_reg;
  assign regs.addr = ptr_reg;
  assign regs.wrData = rxShift_reg;

  // Register store with registered read data
  lrs_reg_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .regs(regs.store),
    .status1(status1),
    .status2(status2),
    .ctrlData(ctrlData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  AST_START_DETECT: assert property (
    @(posedge clk) disable iff (sys_rst)
    startSeen && !stopSeen |=> state_reg == LRS_ST_RX && bitCnt_reg == 4'h0)
    else $error("start not taken");

  AST_STOP_DETECT: assert property (
    @(posedge clk) disable iff (sys_rst)
    stopSeen |=> state_reg == LRS_ST_IDLE && sdaOe_n)
    else $error("stop did not end transfer");

  AST_MSB_FIRST: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == LRS_ST_RX && sclRise && bitCnt_reg < LRS_BYTE_BITS
      && !startSeen && !stopSeen) |=> rxShift_reg[0] == $past(sdaS_reg))
    else $error("receive bit not shifted in at lsb");

  AST_ACK_STEADY: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == LRS_ST_ACK && !sdaOe_n && sclS_reg) |=>
      !sdaOe_n || $past(stopSeen || startSeen))
    else $error("ack released while clock high");

  AST_UVLO_NO_ACK: assert property (
    @(posedge clk) disable iff (sys_rst)
    (byteDone && uvloS_reg && !startSeen && !stopSeen) |=> sdaOe_n [*2])
    else $error("ack driven under lockout");

  AST_WRITE_ADVANCE: assert property (
    @(posedge clk) disable iff (sys_rst)
    wrEn_reg && !byteDone |=> ptr_reg == 8'($past(ptr_reg) + 8'h01))
    else $error("pointer did not advance after write");

  AST_REG_POINTER: assert property (
    @(posedge clk) disable iff (sys_rst)
    (byteDone && phase_reg == LRS_PH_REG && !startSeen && !stopSeen)
      |=> ptr_reg == $past(rxShift_reg))
    else $error("register address not loaded");

  AST_READ_NEXT: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == LRS_ST_MACK && sclFall && ackLow_reg && !stopSeen
      && !startSeen) |=> state_reg == LRS_ST_TX &&
      txShift_reg == $past(regs.rdData))
    else $error("next byte not sent after master ack");

  AST_NACK_RELEASE: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == LRS_ST_MACK && sclFall && !ackLow_reg) |=>
      state_reg == LRS_ST_IDLE && sdaOe_n)
    else $error("line held after master nack");

  AST_ADDR_MISMATCH: assert property (
    @(posedge clk) disable iff (sys_rst)
    (byteDone && phase_reg == LRS_PH_CHIP && !addrMatch && !stopSeen
      && !startSeen) |=> state_reg == LRS_ST_IDLE && sdaOe_n)
    else $error("foreign chip address answered");

endmodule

`default_nettype wire

// *** bench/lrs_i2c_master_model.sv ***
/*
  Behavioural bus master for the two-wire register slave: start, stop,
  byte send with acknowledge sampling and byte receive with master ack.
  Assumes the wire is resolved outside as a pull-up AND of all drivers.
*/
`default_nettype none

module lrs_i2c_master_model
(
  input wire logic clk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaDrv
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////
  // Bus idle: clock parked high, data released to the pull-up
  initial
  begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end

  // Step just past a clock edge so pins never move on the sampling edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One clock pulse, 4 clk low and 4 clk high, i.e. an 80 ns period
  task automatic bitCycle(input logic b, output logic early,
                          output logic late);
    sclOut = 1'b0;
    tick(2);
    // Data moves only in the middle of the low phase
    sdaDrv = b;
    tick(2);
    sclOut = 1'b1;
    tick(1);
    early = sdaWire;
    tick(3);
    late = sdaWire;
  endtask

  // Data falls while the clock is high
  task automatic start();
    sdaDrv = 1'b1;
    sclOut = 1'b1;
    tick(4);
    sdaDrv = 1'b0;
    tick(4);
  endtask

  // Data rises while the clock is high
  task automatic stop();
    sclOut = 1'b0;
    tick(2);
    sdaDrv = 1'b0;
    tick(2);
    sclOut = 1'b1;
    tick(4);
    sdaDrv = 1'b1;
    tick(4);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Eight bits MSB first, then a released ninth pulse; acked is high only
  // when the wire sat low at both ends of that pulse. The caller decides
  // whether a missing ack aborts or the master just carries on.
  task automatic sendByte(input logic [7:0] b, output logic acked);
    logic e;
    logic l;
    for (int i = 7; i >= 0; i--)
      bitCycle(b[i], e, l);
    bitCycle(1'b1, e, l);
    acked = (e === 1'b0) && (l === 1'b0);
  endtask

  // Eight bits read late in each high phase, then the master's own slot
  task automatic recvByte(input logic mAck, output logic [7:0] b);
    logic e;
    logic l;
    for (int i = 7; i >= 0; i--)
    begin
      bitCycle(1'b1, e, l);
      b[i] = l;
    end
    // Low to ask for more, released to end the read
    bitCycle(!mAck, e, l);
  endtask
endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
/*
  Self-checking bench of the two-wire register slave: burst writes,
  reads from status and data registers, a foreign chip address and the
  supply lockout. Assumes the master model drives the bus pins.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lrs_pkg::*;

  logic clk = 1'b0; // 100 MHz system clock
  logic sys_rst = 1'b1; // Active high reset
  logic sclWire; // Serial clock from the master
  logic sdaDrv; // Master data drive, 1 means released
  logic sdaWire; // Resolved data wire
  logic sdaOut; // Device data level
  logic sdaOe_n; // Device pulls the wire while low
  logic uvloActive = 1'b0; // Supply lockout indication
  logic [6:0] chipAddr = 7'h2A; // Strap value, chosen freely
  logic [7:0] status1 = 8'h96; // Contents of the first status byte
  logic [7:0] status2 = 8'h3A; // Contents of the second status byte
  logic [31:0] ctrlData; // Data register contents
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////
  // Open-drain wire with pull-up: anyone driving low wins
  assign sdaWire = sdaDrv & (sdaOe_n | sdaOut);

  always #5 clk = ~clk;

  lrs_i2c_slave lrs_i2c_slave_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclIn(sclWire),
    .sdaIn(sdaWire),
    .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n),
    .uvloActive(uvloActive),
    .chipAddr(chipAddr),
    .status1(status1),
    .status2(status2),
    .ctrlData(ctrlData)
  );

  lrs_i2c_master_model lrs_i2c_master_model_i (
    .clk(clk),
    .sdaWire(sdaWire),
    .sclOut(sclWire),
    .sdaDrv(sdaDrv)
  );

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_sim();
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chkBit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Write n bytes of d, lowest byte first; the master never aborts on a
  // missing ack, so a silent device still sees the whole transfer
  task automatic writeRegs(input logic [6:0] ca, input logic [7:0] ra,
                           input logic [31:0] d, input int n,
                           input logic expAck);
    logic a;
    lrs_i2c_master_model_i.start();
    lrs_i2c_master_model_i.sendByte({ca, 1'b0}, a);
    chkBit(a, expAck);
    lrs_i2c_master_model_i.sendByte(ra, a);
    chkBit(a, expAck);
    for (int i = 0; i < n; i++)
    begin
      lrs_i2c_master_model_i.sendByte(d[8*i +: 8], a);
      chkBit(a, expAck);
    end
    lrs_i2c_master_model_i.stop();
  endtask

  // Set the pointer, stop, then start again for reading, ack all bytes but the last
  task automatic readRegs(input logic [7:0] ra, input int n,
                          input logic [31:0] exp);
    logic a;
    logic [7:0] b;
    writeRegs(chipAddr, ra, 32'h0, 0, 1'b1);
    lrs_i2c_master_model_i.start();
    lrs_i2c_master_model_i.sendByte({chipAddr, 1'b1}, a);
    chkBit(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      lrs_i2c_master_model_i.recvByte(i < n - 1, b);
      chkVal({24'h0, b}, {24'h0, exp[8*i +: 8]});
    end
    // Device has let go of the wire during the master's high ack
    chkBit(sdaOe_n, 1'b1);
    lrs_i2c_master_model_i.stop();
    chkBit(sdaOe_n, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chkVal(ctrlData, {4{LRS_DATA_RESET}});
    chkBit(sdaOe_n, 1'b1);
    chkBit(sdaOut, 1'b0);
  endtask

  // Bit pattern chosen so a reversed byte order or bit order shows
  task automatic t_write_burst();
    writeRegs(chipAddr, LRS_ADDR_DATA1, 32'h1E6B4D83, 4, 1'b1);
    chkVal(ctrlData, 32'h1E6B4D83);
  endtask

  // Start in the middle of the map and stop after any ack
  task automatic t_write_mid();
    writeRegs(chipAddr, LRS_ADDR_DATA4, 32'h000000C4, 1, 1'b1);
    writeRegs(chipAddr, 8'h03, 32'h00005172, 2, 1'b1);
    chkVal(ctrlData, 32'hC4517283);
  endtask

  task automatic t_read_data();
    readRegs(LRS_ADDR_DATA1, 4, 32'hC4517283);
  endtask

  // Status bytes, then straight on into the first data register
  task automatic t_read_status();
    readRegs(LRS_ADDR_STATUS1, 3, {8'h00, 8'h83, status2, status1});
    readRegs(LRS_ADDR_STATUS2, 1, {24'h0, status2});
  endtask

  // Neighbouring address: no ack and nothing stored
  task automatic t_wrong_addr();
    writeRegs(chipAddr ^ 7'h01, LRS_ADDR_DATA1, 32'hFFFFFFFF, 4,
              1'b0);
    // A byte aimed just past the map is acked but lands nowhere
    writeRegs(chipAddr, LRS_ADDR_DATA4 + 8'h01, 32'h000000FF, 1,
              1'b1);
    chkVal(ctrlData, 32'hC4517283);
    // Reading on past the last data register gives the unmapped byte
    readRegs(LRS_ADDR_DATA4, 2, {16'h0, LRS_UNMAPPED_READ, 8'hC4});
  endtask

  // Lockout silences every ack; clearing it brings them back
  task automatic t_uvlo();
    uvloActive = 1'b1;
    tick(6);
    writeRegs(chipAddr, LRS_ADDR_DATA1, 32'h000000A6, 1, 1'b0);
    // Lockout only silences the acks; the byte is still stored
    chkVal(ctrlData, 32'hC45172A6);
    uvloActive = 1'b0;
    tick(6);
    writeRegs(chipAddr, LRS_ADDR_DATA1, 32'h00000083, 1, 1'b1);
    chkVal(ctrlData, 32'hC4517283);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    // Let the synchronisers leave their reset values
    tick(10);
    t_reset();
    t_write_burst();
    t_write_mid();
    t_read_data();
    t_read_status();
    t_wrong_addr();
    t_uvlo();
    end_sim();
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      end_sim();
    end
  end
endmodule

`default_nettype wire
